// ### hdl/ssr_pkg.sv
// shared constants, enums and carrier structs of the status reporting bank
package ssr_pkg;
    // register widths
    localparam int FLAG_W = 16;
    localparam int ESR_W  = 8;

    // device_state_flags bit positions
    localparam int DEV_LEGACY_BIT = 7;
    localparam int DEV_PLL_BIT    = 8;

    // questionable_summary bit positions
    localparam int QUES_POW_BIT  = 3;
    localparam int QUES_CAL_BIT  = 8;
    localparam int QUES_POWER_UP_SELF_TEST_BIT = 9;

    // questionable_power_flags and questionable_zeroing_flags bit positions
    localparam int QPOW_CORRUPT_BIT = 1;
    localparam int QPOW_ZERO_BIT    = 5;
    localparam int QCAL_FAIL_BIT    = 1;

    // standard_event_flags bit positions
    localparam int ESR_OPC_BIT  = 0;
    localparam int ESR_QERR_BIT = 2;
    localparam int ESR_DEV_BIT  = 3;
    localparam int ESR_EXE_BIT  = 4;
    localparam int ESR_CMD_BIT  = 5;
    localparam int ESR_USR_BIT  = 6;
    localparam int ESR_PON_BIT  = 7;

    // status_summary_byte bit positions
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;

    // reset values and fixed enables of the sub-registers
    localparam logic [ESR_W-1:0]  ESE_RST    = 8'h00;
    localparam logic [FLAG_W-1:0] QEN_RST    = 16'h0000;
    localparam logic [FLAG_W-1:0] SUB_EN_ALL = 16'hFFFF;

    // error codes, two's complement: -200 and -100
    localparam logic [15:0] ERR_LEGACY = 16'hFF38;
    localparam logic [15:0] ERR_CMD    = 16'hFF9C;

    typedef enum logic [3:0] {
        CMD_SET     = 4'h0,
        CMD_ESE_SET = 4'h1,
        CMD_QEN_SET = 4'h2,
        CMD_QUERY   = 4'h3,
        CMD_READ    = 4'h4,
        CMD_OPC     = 4'h5,
        CMD_CLOSE   = 4'h6,
        CMD_BAD     = 4'h7
    } ssr_kind_e;

    typedef enum logic [1:0] {
        CH_LEGACY = 2'h0,
        CH_USBTMC = 2'h1,
        CH_TCPIP  = 2'h2
    } ssr_chan_e;

    typedef enum logic [2:0] {
        SEL_DEV  = 3'h0,
        SEL_QUES = 3'h1,
        SEL_QPOW = 3'h2,
        SEL_QCAL = 3'h3,
        SEL_ESR  = 3'h4,
        SEL_ESE  = 3'h5,
        SEL_STB  = 3'h6,
        SEL_QEN  = 3'h7
    } ssr_sel_e;

    typedef enum logic {
        LK_FREE = 1'b0,
        LK_HELD = 1'b1
    } ssr_lock_e;

    typedef struct packed {
        logic        valid;
        ssr_kind_e   kind;
        ssr_chan_e   chan;
        ssr_sel_e    sel;
        logic [15:0] wdata;
    } ssr_cmd_s;

    typedef struct packed {
        logic        ext_src;
        logic        power_up_self_test_fail;
        logic        meas_corrupt;
        logic        zero_invalid;
        logic        zero_fail;
        logic        manual;
        logic        all_done;
        logic        exec_err;
        logic [15:0] exec_code;
        logic        dev_err;
        logic [15:0] dev_code;
    } ssr_cond_s;
endpackage : ssr_pkg

// ### hdl/ssr_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module ssr_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : ssr_sync
`default_nettype wire

// ### hdl/ssr_event_reg.sv
// sticky event register with clear on read and masked summary
`timescale 1ns/100ps
`default_nettype none
module ssr_event_reg #(
    parameter int W    = 16,
    parameter bit EDGE = 1'b1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_cond,
    input  wire logic [W-1:0] i_mask,
    input  wire logic         i_rd_clr,
    output logic      [W-1:0] o_event,
    output logic              o_summary
);
    logic [W-1:0] prev_q;
    logic [W-1:0] ev_q;
    logic [W-1:0] ev_d;
    logic         sum_q;
    wire  [W-1:0] rise;

    // level sources latch on their rising edge, pulse sources every cycle
    assign rise = EDGE ? (i_cond & ~prev_q) : i_cond;
    // set wins over the clear of a read in the same cycle
    assign ev_d = (ev_q & ~{W{i_rd_clr}}) | rise;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_q <= '0;
            ev_q   <= '0;
            sum_q  <= 1'b0;
        end else if (i_ce) begin
            prev_q <= i_cond;
            ev_q   <= ev_d;
            sum_q  <= |(ev_q & i_mask);
        end
    end

    assign o_event   = ev_q;
    assign o_summary = sum_q;
endmodule : ssr_event_reg
`default_nettype wire

// ### hdl/ssr_status_bank.sv
// status reporting register bank reached through parsed command messages
`timescale 1ns/100ps
`default_nettype none
// Function
// - First legacy-channel setting command takes the lock and sets device bit 7.
// - Setting command on another channel while locked is rejected with -200.
// - Device bit 8 is 1 on internal clock, else follows reference PLL lock.
// - Questionable bit 3 summarises power flags, bit 8 the zeroing flags.
// - Questionable bit 9 flags a failed power-up self test.
// - Power flag bit 1 flags corrupt measurement data.
// - Power flag bit 5 flags an invalid zero correction.
// - Zeroing flag bit 1 flags a failed zeroing.
// - Standard event flags are queryable; their mask is writable and readable.
// - Event bit 0 sets when operation-complete arrives and all work is done.
// - Event bit 2 sets on a read with nothing pending or unread data overrun.
// - Event bit 3 sets on a device error and queues its code unless another error comes in the same cycle.
// - Event bit 4 sets on an execution error and queues its code unless a lock rejection or bad command comes in the same cycle.
// - Event bit 5 sets on a bad command and queues code -100.
// - Event bit 6 sets when switched to manual control.
// - Event bit 7 sets at power on.
// - Status byte bit 5 is the masked OR of the standard event flags.
// - Status byte bit 3 is the masked OR of the questionable flags.
module ssr_status_bank (
    input  wire logic                I_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_CE,
    input  wire ssr_pkg::ssr_cmd_s   I_CMD,
    input  wire ssr_pkg::ssr_cond_s  I_COND,
    input  wire logic                I_PLL_LOCK,
    output logic                     O_RSP_VALID,
    output logic [15:0]              O_RSP_DATA,
    output logic                     O_ERR_VALID,
    output logic [15:0]              O_ERR_CODE,
    output logic [7:0]               O_STATUS_BYTE,
    output logic                     O_LEGACY_LOCK,
    output logic                     O_SET_EXEC
);
    import ssr_pkg::*;

    ssr_lock_e          lock_q;
    ssr_lock_e          lock_d;
    logic [ESR_W-1:0]   ese_q;
    logic [FLAG_W-1:0]  qen_q;
    logic               mav_q;
    logic               opc_pend_q;
    logic               pon_q;
    logic               rsp_valid_q;
    logic [15:0]        rsp_data_q;
    logic               err_valid_q;
    logic [15:0]        err_code_q;
    logic [7:0]         stb_q;
    logic               set_exec_q;
    logic               pll_s;
    logic [FLAG_W-1:0]  pow_ev;
    logic [FLAG_W-1:0]  cal_ev;
    logic [FLAG_W-1:0]  ques_ev;
    logic [ESR_W-1:0]   esr_ev;
    logic               pow_sum;
    logic               cal_sum;
    logic               ques_sum;
    logic               esr_sum;

    // command decode
    wire cmd_go     = I_CE & I_CMD.valid;
    wire is_legacy  = (I_CMD.chan == CH_LEGACY);
    wire set_kind   = (I_CMD.kind == CMD_SET) | (I_CMD.kind == CMD_ESE_SET) | (I_CMD.kind == CMD_QEN_SET);
    wire set_cmd    = cmd_go & set_kind;
    wire reject     = set_cmd & ~is_legacy & (lock_q == LK_HELD);
    wire set_ok     = set_cmd & ~reject;
    wire lock_take  = set_cmd & is_legacy & (lock_q == LK_FREE);
    wire lock_drop  = cmd_go & is_legacy & (I_CMD.kind == CMD_CLOSE);
    wire qry        = cmd_go & (I_CMD.kind == CMD_QUERY);
    wire rd_cmd     = cmd_go & (I_CMD.kind == CMD_READ);
    wire bad_cmd    = cmd_go & (I_CMD.kind == CMD_BAD);
    wire opc_cmd    = cmd_go & (I_CMD.kind == CMD_OPC);
    wire ese_wr     = set_ok & (I_CMD.kind == CMD_ESE_SET);
    wire qen_wr     = set_ok & (I_CMD.kind == CMD_QEN_SET);

    // query errors: read with nothing pending, or new command over unread data
    wire qerr       = (rd_cmd & ~mav_q) | (cmd_go & ~rd_cmd & mav_q);
    wire opc_fire   = I_CE & opc_pend_q & I_COND.all_done;

    // reading an event register clears it
    wire clr_ques   = qry & (I_CMD.sel == SEL_QUES);
    wire clr_pow    = qry & (I_CMD.sel == SEL_QPOW);
    wire clr_cal    = qry & (I_CMD.sel == SEL_QCAL);
    wire clr_esr    = qry & (I_CMD.sel == SEL_ESR);

    // device flags are live levels, not latched events
    wire [FLAG_W-1:0] dev_flags = (FLAG_W'(lock_q == LK_HELD) << DEV_LEGACY_BIT)
                                | (FLAG_W'(~I_COND.ext_src | pll_s) << DEV_PLL_BIT);

    // condition vectors of the questionable tree
    wire [FLAG_W-1:0] pow_cond  = (FLAG_W'(I_COND.meas_corrupt) << QPOW_CORRUPT_BIT)
                                | (FLAG_W'(I_COND.zero_invalid) << QPOW_ZERO_BIT);
    wire [FLAG_W-1:0] cal_cond  = FLAG_W'(I_COND.zero_fail) << QCAL_FAIL_BIT;
    wire [FLAG_W-1:0] ques_cond = (FLAG_W'(pow_sum) << QUES_POW_BIT)
                                | (FLAG_W'(cal_sum) << QUES_CAL_BIT)
                                | (FLAG_W'(I_COND.power_up_self_test_fail) << QUES_POWER_UP_SELF_TEST_BIT);

    // standard event sources, all one-cycle pulses
    wire [ESR_W-1:0] esr_set = (ESR_W'(opc_fire) << ESR_OPC_BIT)
                             | (ESR_W'(qerr) << ESR_QERR_BIT)
                             | (ESR_W'(I_COND.dev_err) << ESR_DEV_BIT)
                             | (ESR_W'(reject | I_COND.exec_err) << ESR_EXE_BIT)
                             | (ESR_W'(bad_cmd) << ESR_CMD_BIT)
                             | (ESR_W'(I_COND.manual) << ESR_USR_BIT)
                             | (ESR_W'(pon_q) << ESR_PON_BIT);

    // error queue entry: one per cycle, the lock rejection ranks first
    wire        err_any  = reject | bad_cmd | I_COND.exec_err | I_COND.dev_err;
    wire [15:0] err_mux  = reject          ? ERR_LEGACY :
                           bad_cmd         ? ERR_CMD :
                           I_COND.exec_err ? I_COND.exec_code :
                           I_COND.dev_code;

    // query response selection
    wire [15:0] rsp_mux  = (I_CMD.sel == SEL_DEV)  ? dev_flags :
                           (I_CMD.sel == SEL_QUES) ? ques_ev :
                           (I_CMD.sel == SEL_QPOW) ? pow_ev :
                           (I_CMD.sel == SEL_QCAL) ? cal_ev :
                           (I_CMD.sel == SEL_ESR)  ? {8'h00, esr_ev} :
                           (I_CMD.sel == SEL_ESE)  ? {8'h00, ese_q} :
                           (I_CMD.sel == SEL_STB)  ? {8'h00, stb_q} :
                           qen_q;

    // summaries feeding the status byte
    wire [7:0] stb_d = (8'(ques_sum) << STB_QUES_BIT)
                     | (8'(mav_q) << STB_MAV_BIT)
                     | (8'(esr_sum) << STB_ESB_BIT);

    // reference PLL lock arrives from another clock domain
    ssr_sync #(.W(1)) u_pll_sync (
        .i_clk   (I_CLK),
        .i_rst   (I_RST),
        .i_ce    (I_CE),
        .i_async (I_PLL_LOCK),
        .o_sync  (pll_s)
    );

    // questionable power and zeroing sub-registers, enables fixed open
    ssr_event_reg #(.W(FLAG_W), .EDGE(1'b1)) u_pow (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_ce      (I_CE),
        .i_cond    (pow_cond),
        .i_mask    (SUB_EN_ALL),
        .i_rd_clr  (clr_pow),
        .o_event   (pow_ev),
        .o_summary (pow_sum)
    );

    ssr_event_reg #(.W(FLAG_W), .EDGE(1'b1)) u_cal (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_ce      (I_CE),
        .i_cond    (cal_cond),
        .i_mask    (SUB_EN_ALL),
        .i_rd_clr  (clr_cal),
        .o_event   (cal_ev),
        .o_summary (cal_sum)
    );

    // questionable summary register, gated by the writable enable
    ssr_event_reg #(.W(FLAG_W), .EDGE(1'b1)) u_ques (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_ce      (I_CE),
        .i_cond    (ques_cond),
        .i_mask    (qen_q),
        .i_rd_clr  (clr_ques),
        .o_event   (ques_ev),
        .o_summary (ques_sum)
    );

    // standard event flags take pulses, so no edge detect that could merge them
    ssr_event_reg #(.W(ESR_W), .EDGE(1'b0)) u_esr (
        .i_clk     (I_CLK),
        .i_rst     (I_RST),
        .i_ce      (I_CE),
        .i_cond    (esr_set),
        .i_mask    (ese_q),
        .i_rd_clr  (clr_esr),
        .o_event   (esr_ev),
        .o_summary (esr_sum)
    );

    // legacy lock state
    always_comb begin
        case (lock_q)
            LK_FREE: lock_d = lock_take ? LK_HELD : LK_FREE;
            LK_HELD: lock_d = lock_drop ? LK_FREE : LK_HELD;
            default: lock_d = LK_FREE;
        endcase
    end

    // control state: lock, masks, pending flags
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lock_q     <= LK_FREE;
            ese_q      <= ESE_RST;
            qen_q      <= QEN_RST;
            mav_q      <= 1'b0;
            opc_pend_q <= 1'b0;
            pon_q      <= 1'b1;
        end else if (I_CE) begin
            lock_q     <= lock_d;
            ese_q      <= ese_wr ? I_CMD.wdata[ESR_W-1:0] : ese_q;
            qen_q      <= qen_wr ? I_CMD.wdata : qen_q;
            mav_q      <= qry | (mav_q & ~cmd_go);
            opc_pend_q <= opc_cmd | (opc_pend_q & ~opc_fire);
            pon_q      <= 1'b0;
        end
    end

    // registered outputs; pulses drop when the clock enable is low
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 16'h0000;
            err_valid_q <= 1'b0;
            err_code_q  <= 16'h0000;
            stb_q       <= 8'h00;
            set_exec_q  <= 1'b0;
        end else if (I_CE) begin
            rsp_valid_q <= qry;
            rsp_data_q  <= qry ? rsp_mux : rsp_data_q;
            err_valid_q <= err_any;
            err_code_q  <= err_any ? err_mux : err_code_q;
            stb_q       <= stb_d;
            set_exec_q  <= set_ok;
        end else begin
            rsp_valid_q <= 1'b0;
            err_valid_q <= 1'b0;
            set_exec_q  <= 1'b0;
        end
    end

    assign O_RSP_VALID   = rsp_valid_q;
    assign O_RSP_DATA    = rsp_data_q;
    assign O_ERR_VALID   = err_valid_q;
    assign O_ERR_CODE    = err_code_q;
    assign O_STATUS_BYTE = stb_q;
    assign O_LEGACY_LOCK = lock_q;
    assign O_SET_EXEC    = set_exec_q;

    // checks, one clock domain
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_legacy_set;
        I_CE && I_CMD.valid && I_CMD.kind == CMD_SET && I_CMD.chan == CH_LEGACY;
    endsequence

    sequence s_foreign_set;
        I_CE && I_CMD.valid && I_CMD.kind == CMD_SET && I_CMD.chan != CH_LEGACY;
    endsequence

    chk_lock_taken: assert property (s_legacy_set ##1 1'b1 |-> O_LEGACY_LOCK)
        else $error("legacy setting command did not take the lock");

    chk_foreign_reject: assert property (O_LEGACY_LOCK ##0 s_foreign_set |=>
        O_ERR_VALID && O_ERR_CODE == ERR_LEGACY && !O_SET_EXEC)
        else $error("foreign setting command under lock not rejected with -200");

    chk_pll_flag: assert property (qry && I_CMD.sel == SEL_DEV && !I_COND.ext_src |=>
        O_RSP_DATA[DEV_PLL_BIT])
        else $error("reference lock flag not forced high on internal clock");

    chk_pow_summary: assert property (I_CE && $past(I_CE) && $rose(pow_sum) |=>
        ques_ev[QUES_POW_BIT])
        else $error("power flag did not reach questionable summary");

    chk_power_up_self_test_latch: assert property (I_CE && $past(I_CE) && $rose(I_COND.power_up_self_test_fail) |=>
        ques_ev[QUES_POWER_UP_SELF_TEST_BIT])
        else $error("self test failure not latched");

    chk_corrupt_latch: assert property (I_CE && $past(I_CE) && $rose(I_COND.meas_corrupt) |=>
        pow_ev[QPOW_CORRUPT_BIT])
        else $error("corrupt measurement not latched");

    chk_zero_needed: assert property (I_CE && $past(I_CE) && $rose(I_COND.zero_invalid) |=>
        pow_ev[QPOW_ZERO_BIT])
        else $error("zero correction need not latched");

    chk_zero_failed: assert property (I_CE && $past(I_CE) && $rose(I_COND.zero_fail) |=>
        cal_ev[QCAL_FAIL_BIT])
        else $error("zeroing failure not latched");

    chk_esr_readout: assert property (clr_esr |=> O_RSP_VALID && O_RSP_DATA == {8'h00, $past(esr_ev)})
        else $error("standard event query returned wrong value");

    chk_esr_cleared: assert property (clr_esr && esr_set == 8'h00 |=> esr_ev == 8'h00)
        else $error("standard event flags not cleared by read");

    chk_opc_done: assert property (opc_fire |=> esr_ev[ESR_OPC_BIT])
        else $error("operation complete not flagged");

    chk_query_err: assert property (rd_cmd && !mav_q |=> esr_ev[ESR_QERR_BIT])
        else $error("read without pending data not flagged");

    chk_bad_cmd: assert property (bad_cmd && !reject |=> O_ERR_VALID && O_ERR_CODE == ERR_CMD
        && esr_ev[ESR_CMD_BIT])
        else $error("bad command not reported");

    chk_esb_summary: assert property (I_CE && $past(I_CE) |=>
        O_STATUS_BYTE[STB_ESB_BIT] == $past(esr_sum))
        else $error("event summary bit does not follow masked flags");
endmodule : ssr_status_bank
`default_nettype wire

// ### verif/ssr_ctrl_model.sv
// remote controller model that issues parsed command messages
`timescale 1ns/100ps
`default_nettype none
module ssr_ctrl_model (
    input  wire logic              i_clk,
    output var  ssr_pkg::ssr_cmd_s o_cmd
);
    import ssr_pkg::*;

    initial o_cmd = '0;

    // one command per call; afterwards valid drops and wdata is inverted so no stale value is mistaken for a command
    task automatic send(input ssr_kind_e kind, input ssr_chan_e chan, input ssr_sel_e sel, input logic [15:0] wd);
        @(negedge i_clk);
        o_cmd = '{valid: 1'b1, kind: kind, chan: chan, sel: sel, wdata: wd};
        @(negedge i_clk);
        o_cmd.valid = 1'b0;
        o_cmd.wdata = ~wd;
    endtask : send

    // dropping the legacy channel is the only way out of the lock
    task automatic close_legacy;
        send(CMD_CLOSE, CH_LEGACY, SEL_DEV, 16'h0000);
    endtask : close_legacy
endmodule : ssr_ctrl_model
`default_nettype wire

// ### verif/tb_ssr_status_bank.sv
// self-checking bench for the status reporting bank
`timescale 1ns/100ps
`default_nettype none
module tb_ssr_status_bank;
    import ssr_pkg::*;
    logic        clk;
    logic        rst;
    ssr_cmd_s    cmd;
    ssr_cond_s   cond;
    logic        pll;
    logic        ce;
    logic        rsp_v;
    logic [15:0] rsp_d;
    logic        err_v;
    logic [15:0] err_c;
    logic [7:0]  stb;
    logic        lock;
    logic        set_x;
    int          mismatches;
    int          comparisons;
    logic [15:0] d;

    ssr_status_bank i_dut (
        .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CMD(cmd), .I_COND(cond), .I_PLL_LOCK(pll),
        .O_RSP_VALID(rsp_v), .O_RSP_DATA(rsp_d), .O_ERR_VALID(err_v), .O_ERR_CODE(err_c),
        .O_STATUS_BYTE(stb), .O_LEGACY_LOCK(lock), .O_SET_EXEC(set_x)
    );
    ssr_ctrl_model i_ctrl (.i_clk(clk), .o_cmd(cmd));

    // free running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk1(input string nm, input logic exp, input logic got);
        chk(nm, {15'h0000, exp}, {15'h0000, got});
    endtask : chk1

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    // query then collect, so no query error is left behind
    task automatic q(input ssr_sel_e sel, output logic [15:0] v);
        i_ctrl.send(CMD_QUERY, CH_TCPIP, sel, 16'h0000);
        chk1("rsp_valid", 1'b1, rsp_v);
        v = rsp_d;
        i_ctrl.send(CMD_READ, CH_TCPIP, sel, 16'h0000);
    endtask : q

    // one cycle error source, dev selects device error else execution error
    task automatic err_pulse(input logic dev, input logic [15:0] code);
        @(negedge clk);
        cond.dev_err = dev;
        cond.exec_err = ~dev;
        cond.dev_code = code;
        cond.exec_code = code;
        @(negedge clk);
        cond.dev_err = 1'b0;
        cond.exec_err = 1'b0;
        chk1("err_valid", 1'b1, err_v);
        chk("err_code", code, err_c);
    endtask : err_pulse

    task automatic t_power_on;
        q(SEL_ESR, d);
        chk("esr_pon", 16'h0080, d);
        q(SEL_ESR, d);
        chk("esr_clr", 16'h0000, d);
        $display("test power_on done");
    endtask : t_power_on

    task automatic t_lock;
        i_ctrl.send(CMD_SET, CH_LEGACY, SEL_DEV, 16'h0000);
        chk1("set_exec", 1'b1, set_x);
        chk1("lock", 1'b1, lock);
        i_ctrl.send(CMD_SET, CH_USBTMC, SEL_DEV, 16'h0000);
        chk1("set_exec_usb", 1'b0, set_x);
        chk1("err_usb", 1'b1, err_v);
        chk("code_usb", 16'hFF38, err_c);
        i_ctrl.send(CMD_ESE_SET, CH_TCPIP, SEL_ESE, 16'h00FF);
        chk1("err_tcp", 1'b1, err_v);
        q(SEL_DEV, d);
        chk("dev_bits", 16'h0180, d & 16'h0180);
        i_ctrl.close_legacy();
        chk1("lock_free", 1'b0, lock);
        i_ctrl.send(CMD_SET, CH_USBTMC, SEL_DEV, 16'h0000);
        chk1("set_usb_ok", 1'b1, set_x);
        q(SEL_ESR, d);
        chk("esr_exe", 16'h0010, d);
        $display("test lock done");
    endtask : t_lock

    task automatic t_pll;
        cond.ext_src = 1'b1;
        wt(4);
        q(SEL_DEV, d);
        chk("pll_ext_out", 16'h0000, d & 16'h0100);
        pll = 1'b1;
        wt(4);
        q(SEL_DEV, d);
        chk("pll_ext_in", 16'h0100, d & 16'h0100);
        cond.ext_src = 1'b0;
        pll = 1'b0;
        wt(4);
        q(SEL_DEV, d);
        chk("pll_int", 16'h0100, d & 16'h0100);
        $display("test pll done");
    endtask : t_pll

    task automatic t_ques;
        cond.meas_corrupt = 1'b1;
        cond.zero_invalid = 1'b1;
        cond.zero_fail = 1'b1;
        cond.power_up_self_test_fail = 1'b1;
        i_ctrl.send(CMD_QEN_SET, CH_USBTMC, SEL_QEN, 16'h0008);
        wt(6);
        chk1("stb_ques", 1'b1, stb[3]);
        q(SEL_QEN, d);
        chk("qen", 16'h0008, d);
        q(SEL_QUES, d);
        chk("ques", 16'h0308, d);
        q(SEL_QPOW, d);
        chk("qpow", 16'h0022, d);
        q(SEL_QCAL, d);
        chk("qcal", 16'h0002, d);
        cond.meas_corrupt = 1'b0;
        cond.zero_invalid = 1'b0;
        cond.zero_fail = 1'b0;
        cond.power_up_self_test_fail = 1'b0;
        wt(4);
        chk1("stb_ques_off", 1'b0, stb[3]);
        $display("test questionable done");
    endtask : t_ques

    task automatic t_events;
        i_ctrl.send(CMD_ESE_SET, CH_USBTMC, SEL_ESE, 16'h003C);
        chk1("ese_set", 1'b1, set_x);
        err_pulse(1'b1, 16'h0005);
        err_pulse(1'b0, 16'hFF00);
        i_ctrl.send(CMD_BAD, CH_USBTMC, SEL_DEV, 16'h0000);
        chk("code_bad", 16'hFF9C, err_c);
        @(negedge clk);
        cond.manual = 1'b1;
        @(negedge clk);
        cond.manual = 1'b0;
        i_ctrl.send(CMD_OPC, CH_USBTMC, SEL_DEV, 16'h0000);
        i_ctrl.send(CMD_READ, CH_TCPIP, SEL_DEV, 16'h0000);
        wt(4);
        chk1("stb_esb", 1'b1, stb[5]);
        q(SEL_ESR, d);
        chk("esr_all", 16'h007D, d);
        q(SEL_ESE, d);
        chk("ese", 16'h003C, d);
        wt(4);
        chk1("stb_esb_off", 1'b0, stb[5]);
        $display("test events done");
    endtask : t_events

    // unread data overrun, then a low clock enable that must drop a command and an event
    task automatic t_hold;
        i_ctrl.send(CMD_QUERY, CH_USBTMC, SEL_STB, 16'h0000);
        @(negedge clk);
        chk1("stb_mav", 1'b1, stb[4]);
        i_ctrl.send(CMD_QUERY, CH_USBTMC, SEL_STB, 16'h0000);
        i_ctrl.send(CMD_READ, CH_USBTMC, SEL_STB, 16'h0000);
        q(SEL_ESR, d);
        chk("esr_overrun", 16'h0004, d);
        ce = 1'b0;
        cond.manual = 1'b1;
        i_ctrl.send(CMD_SET, CH_LEGACY, SEL_DEV, 16'h0000);
        chk1("frozen_set", 1'b0, set_x);
        chk1("frozen_lock", 1'b0, lock);
        cond.manual = 1'b0;
        ce = 1'b1;
        q(SEL_ESR, d);
        chk("frozen_esr", 16'h0000, d);
        $display("test hold done");
    endtask : t_hold

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // hang guard, far beyond the some 130 cycles the tests need
    initial begin
        #200000;
        mismatches++;
        results();
    end

    // reset, then the scenarios in order
    initial begin
        rst = 1'b1;
        cond = '0;
        cond.all_done = 1'b1;
        ce = 1'b1;
        pll = 1'b0;
        mismatches = 0;
        comparisons = 0;
        wt(8);
        rst = 1'b0;
        t_power_on();
        t_lock();
        t_pll();
        t_ques();
        t_events();
        t_hold();
        results();
    end
endmodule : tb_ssr_status_bank
`default_nettype wire
